// [include/epb_pkg.sv]
// Shared constants, state types and lane helpers of the external parallel bus port
package epb_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 24;             // External address pins
  localparam int DATA_W     = 48;             // External data pins, all lanes
  localparam int BANKS      = 4;              // Memory banks, one select each
  localparam int BANK_IDX_W = 2;              // Bank index width
  localparam int ID_W       = 3;              // Processor identity pins
  localparam int IOP_AW_DEF = 17;             // IO_PROCESSOR_REGS register address width

  // ---------------------------------------------------------------
  // Bank decode: 16M words plain memory, 64M words SDRAM
  // ---------------------------------------------------------------
  localparam int BANK_LSB_MEM = 24;           // Bank field for plain memory
  localparam int BANK_LSB_SDR = 26;           // Bank field for SDRAM
  localparam int REQ_AW       = BANK_LSB_SDR + BANK_IDX_W;
  localparam logic [BANKS-1:0] BANK_NONE = 4'hF;  // No bank selected

  // ---------------------------------------------------------------
  // Data lanes
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] LANE_HI  = 48'hFFFF_FFFF_0000;  // Always present
  localparam logic [DATA_W-1:0] LANE_MID = 48'h0000_0000_FF00;  // Shared with link 1
  localparam logic [DATA_W-1:0] LANE_LO  = 48'h0000_0000_00FF;  // Shared with link 0

  // ---------------------------------------------------------------
  // Configuration codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]      IPACK_NOPACK = 2'h1;   // Full width, no packing
  localparam logic [ID_W-1:0] ID_KEEP_MASK = 3'h6;   // Identity bits that matter
  localparam logic [ID_W-1:0] ID_KEEP_VAL  = 3'h0;   // Identity that enables keepers
  localparam logic            RST_STROBE_N = 1'b1;   // Strobes idle high
  localparam logic            RST_SEL_N    = 1'b1;   // Host select idle high

  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    M_IDLE = 2'b00,
    M_STRB = 2'b01,
    M_END  = 2'b10
  } epb_mst_e;

  typedef enum logic [1:0]
  {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_DONE = 2'b10
  } epb_slv_e;

  // Usable data lanes for the current link port use
  function automatic logic [DATA_W-1:0] epb_lanes(input logic l0_use, input logic l1_use);
    logic [DATA_W-1:0] m;
    m = LANE_HI;
    if (!l1_use)
    begin
      m = m | LANE_MID;
    end
    if (!l1_use && !l0_use)
    begin
      m = m | LANE_LO;
    end
    return m;
  endfunction

endpackage

// [design/epb_sync.sv]
// Two-flop synchroniser for asynchronous input levels
`timescale 1ns/100ps
`default_nettype none

module epb_sync
#(
  parameter int   W   = 1,     // Bits to synchronise
  parameter logic RST = 1'b0   // Reset level of both stages
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Asynchronous input and synchronised output
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;        // First stage, read only by second stage

  // ---------------------------------------------------------------
  // Two stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_q <= {W{RST}};
      q_o    <= {W{RST}};
    end
    else if (ce)
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

`default_nettype wire

// [design/epb_keeper.sv]
// Per-bit keeper: remembers the last level driven on a shared pin
`timescale 1ns/100ps
`default_nettype none

module epb_keeper
#(
  parameter int W = 1          // Pins covered
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Pin view
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] pin_oe,
  // Held level
  output var  logic [W-1:0] keep_o
);

  // ---------------------------------------------------------------
  // One holding flop per pin
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    // Own drive wins, otherwise track whatever the wire shows
    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        keep_o[i] <= 1'b0;
      end
      else if (ce)
      begin
        keep_o[i] <= pin_oe[i] ? pin_o[i] : pin_i[i];
      end
    end
  end

endmodule

`default_nettype wire

// [design/epb_port.sv]
// External parallel bus port: bus master toward memory, slave for IO_PROCESSOR_REGS registers
`timescale 1ns/100ps
`default_nettype none

module epb_port
  import epb_pkg::*;
#(
  parameter int IOP_AW = IOP_AW_DEF            // IO_PROCESSOR_REGS register address width
)(
  // Clock, reset, clock enable
  input  wire logic                CLK_SYS,
  input  wire logic                NRST,
  input  wire logic                CE,
  // Role and configuration
  input  wire logic                BUS_MASTER,
  input  wire logic [ID_W-1:0]     PROC_ID,
  input  wire logic [1:0]          IPACK,
  input  wire logic                LINK0_USE,
  input  wire logic                LINK1_USE,
  // Core request and response
  input  wire logic                REQ_VALID,
  input  wire logic                REQ_WRITE,
  input  wire logic                REQ_FETCH,
  input  wire logic                REQ_SYNC,
  input  wire logic                REQ_SDRAM,
  input  wire logic                REQ_PEER,
  input  wire logic [REQ_AW-1:0]   REQ_ADDR,
  input  wire logic [DATA_W-1:0]   REQ_WDATA,
  output var  logic                REQ_READY,
  output var  logic                RSP_VALID,
  output var  logic [DATA_W-1:0]   RSP_RDATA,
  output var  logic                RSP_FULL,
  // IO_PROCESSOR_REGS register side
  output var  logic                IOP_REQ,
  output var  logic                IOP_WRITE,
  output var  logic [IOP_AW-1:0]   IOP_ADDR,
  output var  logic [DATA_W-1:0]   IOP_WDATA,
  input  wire logic                IOP_DONE,
  input  wire logic [DATA_W-1:0]   IOP_RDATA,
  // Address and data pins
  input  wire logic [ADDR_W-1:0]   EXT_ADDR_I,
  output var  logic [ADDR_W-1:0]   EXT_ADDR_O,
  output var  logic                EXT_ADDR_OE,
  input  wire logic [DATA_W-1:0]   EXT_DATA_I,
  output var  logic [DATA_W-1:0]   EXT_DATA_O,
  output var  logic [DATA_W-1:0]   EXT_DATA_OE,
  // Bank select and strobe pins
  input  wire logic [BANKS-1:0]    BANK_SEL_N_I,
  output var  logic [BANKS-1:0]    BANK_SEL_N_O,
  output var  logic                BANK_SEL_N_OE,
  input  wire logic                RD_N_I,
  output var  logic                RD_N_O,
  output var  logic                RD_N_OE,
  input  wire logic                WR_N_I,
  output var  logic                WR_N_O,
  output var  logic                WR_N_OE,
  // Acknowledge, suspend and host select
  input  wire logic                ACK_I,
  output var  logic                ACK_O,
  output var  logic                ACK_OE,
  input  wire logic                BUS_SUSPEND_N,
  input  wire logic                HOST_SEL_N,
  // Monitor and keepers
  output var  logic [BANKS-1:0]    BANK_MON,
  output logic                     KEEP_EN,
  output logic [ADDR_W-1:0]        EXT_ADDR_KEEP,
  output logic [DATA_W-1:0]        EXT_DATA_KEEP
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (IOP_AW < 1 || IOP_AW + ID_W >= ADDR_W)
  begin : g_bad_aw
    $error("IOP_AW does not fit the address bus");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  epb_mst_e            m_q;            // Master state
  epb_slv_e            s_q;            // Slave state
  logic                wr_q;           // Held access is a write
  logic                sync_q;         // Held access is synchronous
  logic [DATA_W-1:0]   mask_q;         // Held data lanes
  logic                host_sel_n_s;   // Synchronised host select
  logic [BANK_IDX_W-1:0] req_bank_idx; // Bank field of request
  logic                req_bank_ok;    // Request hits a bank
  logic [BANKS-1:0]    req_bank_n;     // Decoded request selects
  logic                req_full;       // Request is an unpacked fetch
  logic [DATA_W-1:0]   req_mask;       // Lanes of the request
  logic [DATA_W-1:0]   cur_lanes;      // Lanes free of link ports
  logic                acc;            // Request taken this cycle
  logic                ack_ok;         // Acknowledge seen, not suspended
  logic                m_busy_nx;      // Master owns address next cycle
  logic                wr_nx;          // Write flag next cycle
  logic [DATA_W-1:0]   mask_nx;        // Lanes next cycle
  logic                iop_hit;        // Slave access aimed at us
  logic                s_start;        // Slave access begins
  logic                s_done_nx;      // Slave drives answer next cycle

  // Host select arrives asynchronously
  epb_sync #(.W(1), .RST(RST_SEL_N)) u_sel_sync
  (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .ce   (CE),
    .d_i  (HOST_SEL_N),
    .q_o  (host_sel_n_s)
  );

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  // Bank field sits higher for SDRAM: 64M instead of 16M words
  assign req_bank_idx = REQ_SDRAM ? REQ_ADDR[BANK_LSB_SDR +: BANK_IDX_W]
                                  : REQ_ADDR[BANK_LSB_MEM +: BANK_IDX_W];
  // Peer IO_PROCESSOR_REGS accesses carry no bank select
  assign req_bank_ok  = !REQ_PEER && (REQ_SDRAM || REQ_ADDR[BANK_LSB_SDR +: BANK_IDX_W] == '0);

  // One active-low select per bank from upper address bits
  for (genvar b = 0; b < BANKS; b++)
  begin : g_bank
    assign req_bank_n[b] = !(req_bank_ok && req_bank_idx == BANK_IDX_W'(b));
  end

  // Extra lanes only when link ports leave them free
  assign cur_lanes = epb_lanes(LINK0_USE, LINK1_USE);
  // Unpacked full-width fetch needs packing code and all lanes
  assign req_full  = REQ_FETCH && IPACK == IPACK_NOPACK && (&cur_lanes);
  // Otherwise fetches use the upper lines only, data the upper lines plus free lanes
  assign req_mask  = (REQ_FETCH && !req_full) ? LANE_HI : cur_lanes;

  assign acc       = m_q == M_IDLE && s_q == S_IDLE && REQ_VALID && REQ_READY
                     && BUS_MASTER && BUS_SUSPEND_N;
  // Outside party stretches the access by holding acknowledge low
  assign ack_ok    = ACK_I && BUS_SUSPEND_N;
  assign m_busy_nx = acc || (m_q == M_STRB && !(ack_ok && sync_q));
  assign wr_nx     = acc ? REQ_WRITE : wr_q;
  assign mask_nx   = acc ? req_mask : mask_q;

  // ---------------------------------------------------------------
  // Master state, address, selects and strobes
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      // Idle with strobes high
      m_q          <= M_IDLE;
      RD_N_O       <= RST_STROBE_N;
      WR_N_O       <= RST_STROBE_N;
      BANK_SEL_N_O <= BANK_NONE;
      EXT_ADDR_O   <= '0;
      wr_q         <= 1'b0;
      sync_q       <= 1'b0;
      mask_q       <= '0;
      RSP_FULL     <= 1'b0;
    end
    else if (CE)
    begin
      unique case (m_q)
        M_IDLE:
        begin
          // Address, select and strobe start together
          if (acc)
          begin
            m_q          <= M_STRB;
            EXT_ADDR_O   <= REQ_ADDR[ADDR_W-1:0];
            BANK_SEL_N_O <= req_bank_n;
            RD_N_O       <= REQ_WRITE;
            WR_N_O       <= !REQ_WRITE;
            wr_q         <= REQ_WRITE;
            sync_q       <= REQ_SYNC;
            mask_q       <= req_mask;
            RSP_FULL     <= req_full;
          end
        end
        M_STRB:
        begin
          // Address and select frozen until acknowledge
          if (ack_ok)
          begin
            RD_N_O <= 1'b1;
            WR_N_O <= 1'b1;
            if (sync_q)
            begin
              // Select drops after the acknowledged cycle
              BANK_SEL_N_O <= BANK_NONE;
              m_q          <= M_IDLE;
            end
            else
            begin
              m_q <= M_END;
            end
          end
        end
        M_END:
        begin
          // Select releases with the address drive
          BANK_SEL_N_O <= BANK_NONE;
          m_q          <= M_IDLE;
        end
        default:
        begin
          m_q <= M_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin enables, ready and response
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      EXT_ADDR_OE <= 1'b0;
      RD_N_OE     <= 1'b0;
      REQ_READY   <= 1'b0;
      RSP_VALID   <= 1'b0;
      RSP_RDATA   <= '0;
    end
    else if (CE)
    begin
      // Floated while suspended or slave; address is then input
      EXT_ADDR_OE <= BUS_MASTER && BUS_SUSPEND_N && m_busy_nx;
      // Only the master drives strobes and selects
      RD_N_OE     <= BUS_MASTER && BUS_SUSPEND_N;
      REQ_READY   <= !m_busy_nx && !(m_q == M_STRB);
      RSP_VALID   <= m_q == M_STRB && ack_ok && !wr_q;
      if (m_q == M_STRB && ack_ok && !wr_q)
      begin
        RSP_RDATA <= EXT_DATA_I & mask_q;
      end
    end
  end

  assign WR_N_OE       = RD_N_OE;
  assign BANK_SEL_N_OE = RD_N_OE;

  // ---------------------------------------------------------------
  // Data pins: master write data or slave read answer
  // ---------------------------------------------------------------
  assign s_done_nx = (s_q == S_WAIT && IOP_DONE) || (s_q == S_DONE && !(RD_N_I && WR_N_I));

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      EXT_DATA_O  <= '0;
      EXT_DATA_OE <= '0;
    end
    else if (CE)
    begin
      // Write data held for the whole strobe
      if (acc && REQ_WRITE)
      begin
        EXT_DATA_O <= REQ_WDATA & req_mask;
      end
      else if (s_q == S_WAIT && IOP_DONE && !IOP_WRITE)
      begin
        EXT_DATA_O <= IOP_RDATA & cur_lanes;
      end
      // Lanes driven per mode
      if (BUS_MASTER && BUS_SUSPEND_N && m_busy_nx && wr_nx)
      begin
        EXT_DATA_OE <= mask_nx;
      end
      else if (!BUS_MASTER && BUS_SUSPEND_N && s_done_nx && !IOP_WRITE)
      begin
        EXT_DATA_OE <= cur_lanes;
      end
      else
      begin
        EXT_DATA_OE <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Slave access to our IO_PROCESSOR_REGS registers
  // ---------------------------------------------------------------
  // Selected by host, or by our identity in the IO_PROCESSOR_REGS address space
  assign iop_hit = !host_sel_n_s
                   || (EXT_ADDR_I[ADDR_W-1:IOP_AW+ID_W] == '0
                       && EXT_ADDR_I[IOP_AW +: ID_W] == PROC_ID && (&BANK_SEL_N_I));
  // Outside party owns the strobes
  assign s_start = s_q == S_IDLE && !BUS_MASTER && iop_hit && !(RD_N_I && WR_N_I);

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      s_q       <= S_IDLE;
      IOP_REQ   <= 1'b0;
      IOP_WRITE <= 1'b0;
      IOP_ADDR  <= '0;
      IOP_WDATA <= '0;
      ACK_O     <= 1'b1;
      ACK_OE    <= 1'b0;
    end
    else if (CE)
    begin
      IOP_REQ <= 1'b0;
      unique case (s_q)
        S_IDLE:
        begin
          // Address taken as input
          if (s_start)
          begin
            s_q       <= S_WAIT;
            IOP_REQ   <= 1'b1;
            IOP_WRITE <= !WR_N_I;
            IOP_ADDR  <= EXT_ADDR_I[IOP_AW-1:0];
            IOP_WDATA <= EXT_DATA_I & cur_lanes;
            ACK_OE    <= 1'b1;
            ACK_O     <= 1'b0;
          end
        end
        S_WAIT:
        begin
          // Wait states by holding acknowledge low
          if (IOP_DONE)
          begin
            s_q   <= S_DONE;
            ACK_O <= 1'b1;
          end
        end
        S_DONE:
        begin
          // Release once both strobes are back high
          if (RD_N_I && WR_N_I)
          begin
            s_q    <= S_IDLE;
            ACK_OE <= 1'b0;
          end
        end
        default:
        begin
          s_q <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bank select monitor and keeper enable
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      BANK_MON <= BANK_NONE;
      KEEP_EN  <= 1'b0;
    end
    else if (CE)
    begin
      // Follow the master's selects while slave
      if (!BUS_MASTER)
      begin
        BANK_MON <= BANK_SEL_N_I;
      end
      // Keepers only on identity 00x
      KEEP_EN <= (PROC_ID & ID_KEEP_MASK) == ID_KEEP_VAL;
    end
  end

  // Last driven level of address and data pins
  epb_keeper #(.W(ADDR_W)) u_addr_keep
  (
    .clk    (CLK_SYS),
    .nrst   (NRST),
    .ce     (CE),
    .pin_i  (EXT_ADDR_I),
    .pin_o  (EXT_ADDR_O),
    .pin_oe ({ADDR_W{EXT_ADDR_OE}}),
    .keep_o (EXT_ADDR_KEEP)
  );

  epb_keeper #(.W(DATA_W)) u_data_keep
  (
    .clk    (CLK_SYS),
    .nrst   (NRST),
    .ce     (CE),
    .pin_i  (EXT_DATA_I),
    .pin_o  (EXT_DATA_O),
    .pin_oe (EXT_DATA_OE),
    .keep_o (EXT_DATA_KEEP)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_slave_addr_in: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && !BUS_MASTER) |=> !EXT_ADDR_OE && !RD_N_OE && !WR_N_OE)
    else $error("pins driven while slave");
  a_suspend_float: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && !BUS_SUSPEND_N) |=> !EXT_ADDR_OE && !BANK_SEL_N_OE && !RD_N_OE)
    else $error("pins driven while suspended");
  a_strobe_stable: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    ((!RD_N_O || !WR_N_O) && $past(!RD_N_O || !WR_N_O))
      |-> $stable(EXT_ADDR_O) && $stable(BANK_SEL_N_O) && $stable(EXT_DATA_O))
    else $error("address or data moved under strobe");
  a_sync_release: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && m_q == M_STRB && sync_q && ack_ok)
      |=> BANK_SEL_N_O == BANK_NONE && RD_N_O && WR_N_O && !EXT_ADDR_OE)
    else $error("synchronous select not released");
  a_async_hold: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && m_q == M_STRB && !sync_q && ack_ok)
      |=> $stable(BANK_SEL_N_O) && RD_N_O && WR_N_O)
    else $error("asynchronous select left before address");
  a_bank_decode: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && acc) |=> BANK_SEL_N_O == $past(req_bank_n) && $countones(~BANK_SEL_N_O) <= 1)
    else $error("bank select decode wrong");
  a_ack_wait: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && s_start) |=> (ACK_OE && !ACK_O) throughout (s_q == S_WAIT))
    else $error("acknowledge not held low");
  a_keep_enable: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    CE |=> KEEP_EN == (($past(PROC_ID) & ID_KEEP_MASK) == ID_KEEP_VAL))
    else $error("keeper enable wrong");
  a_full_fetch: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CE && acc) |=> RSP_FULL == $past(req_full))
    else $error("full width fetch flag wrong");
  a_reset_idle: assert property (
    @(posedge CLK_SYS)
    !NRST |=> RD_N_O && WR_N_O && m_q == M_IDLE && !ACK_OE)
    else $error("not idle after reset");

endmodule

`default_nettype wire

// [testbench/epb_mem_model.sv]
// Memory partner: acknowledge wait states and read data on the pins
`timescale 1ns/100ps
`default_nettype none
module epb_mem_model
  import epb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [1:0]        waits,
  input  wire logic [DATA_W-1:0] word,
  output logic                   ack,
  output logic [DATA_W-1:0]      rdata
);
  logic [1:0] cnt_q; // Wait cycles served so far
  // Count wait cycles while a strobe is low
  always_ff @(posedge clk)
  begin
    if (rd_n & wr_n)
      cnt_q <= 2'h0;
    else if (cnt_q != waits)
      cnt_q <= cnt_q + 2'h1;
  end
  assign ack = (rd_n & wr_n) | (cnt_q == waits);
  // Released data lines show the inverse, never a stale word
  assign rdata = rd_n ? ~word : word;
endmodule
`default_nettype wire

// [testbench/epb_port_tb.sv]
// Self-checking bench of the external parallel bus port
`timescale 1ns/100ps
`default_nettype none
module epb_port_tb
  import epb_pkg::*;
;
  logic CLK_SYS=0, NRST=0, CE=1, BUS_MASTER=1, LINK0_USE=1, LINK1_USE=1, REQ_VALID=0;
  logic REQ_WRITE=0, REQ_FETCH=0, REQ_SYNC=0, REQ_SDRAM=0, REQ_PEER=0, IOP_DONE=0;
  logic BUS_SUSPEND_N=1, HOST_SEL_N=1, ext_rd_n=1, ext_wr_n=1, mem_ack;
  logic [2:0] PROC_ID=3'h1;
  logic [1:0] IPACK=2'h0;
  logic [27:0] REQ_ADDR=28'h0;
  logic [47:0] REQ_WDATA=48'h0, IOP_RDATA=48'h0, word=48'h0, mem_d;
  logic [23:0] EXT_ADDR_I=24'h0;
  logic [3:0] BANK_SEL_N_I=4'hF;
  logic REQ_READY, RSP_VALID, RSP_FULL, IOP_REQ, IOP_WRITE, EXT_ADDR_OE, BANK_SEL_N_OE;
  logic RD_N_O, RD_N_OE, WR_N_O, WR_N_OE, ACK_O, ACK_OE, KEEP_EN;
  logic [47:0] RSP_RDATA, IOP_WDATA, EXT_DATA_O, EXT_DATA_OE, EXT_DATA_KEEP;
  logic [16:0] IOP_ADDR;
  logic [23:0] EXT_ADDR_O, EXT_ADDR_KEEP;
  logic [3:0] BANK_SEL_N_O, BANK_MON;
  // Pin resolution: the driving party wins, strobes and acknowledge pull up
  wire RD_N_I = RD_N_OE ? RD_N_O : ext_rd_n;
  wire WR_N_I = WR_N_OE ? WR_N_O : ext_wr_n;
  wire ACK_I = ACK_OE ? ACK_O : mem_ack;
  wire [47:0] EXT_DATA_I = (EXT_DATA_OE & EXT_DATA_O) | (~EXT_DATA_OE & mem_d);
  int n_errors = 0, checks_done = 0, k;
  logic [36:0] r = 37'h0; // write, sync, sdram, waits, bank select, address
  logic [36:0] rows [5] = '{{5'b01001, 4'hD, 28'h1123456}, {5'b10100, 4'h7, 28'hCABCDEF},
    {5'b00010, 4'hE, 28'h0000010}, {5'b01100, 4'hB, 28'h8654321},
    {5'b00000, 4'hF, 28'h4000020}};
  epb_port epb_port_inst (.*);
  epb_mem_model epb_mem_model_inst (.clk(CLK_SYS), .rd_n(RD_N_I), .wr_n(WR_N_I),
    .waits(r[33:32]), .word(word), .ack(mem_ack), .rdata(mem_d));
  always #2.5 CLK_SYS = ~CLK_SYS;
  // Compare one value and count it
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One master access from a row, checked on the pins and in the answer
  task automatic access(input logic [36:0] row, input logic [47:0] lanes, input logic full);
    for (k = 0; k < 20 && !REQ_READY; k++) @(negedge CLK_SYS);
    @(posedge CLK_SYS);
    r <= row;
    word <= {20'hABCDE, row[27:0]};
    REQ_WDATA <= {20'hABCDE, row[27:0]};
    {REQ_WRITE, REQ_SYNC, REQ_SDRAM, REQ_ADDR} <= {row[36:34], row[27:0]};
    REQ_VALID <= 1'b1;
    @(posedge CLK_SYS) REQ_VALID <= 1'b0;
    for (k = 0; k < 9 && (RD_N_O & WR_N_O); k++) @(negedge CLK_SYS);
    while (!(RD_N_O & WR_N_O))
    begin
      chk({BANK_SEL_N_O, EXT_ADDR_O}, {r[31:28], r[23:0]});
      if (r[36]) chk(EXT_DATA_O & EXT_DATA_OE, word & lanes);
      @(negedge CLK_SYS);
    end
    if (!r[36]) chk({RSP_VALID, RSP_FULL, RSP_RDATA}, {1'b1, full, word & lanes});
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #20000;
    n_errors++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    @(negedge CLK_SYS) chk({RD_N_O, WR_N_O, REQ_READY, BANK_SEL_N_O}, 7'h6F);
    @(posedge CLK_SYS) NRST <= 1'b1;
    repeat (2) @(negedge CLK_SYS);
    chk({KEEP_EN, RD_N_OE, RD_N_O}, 3'h7);
    foreach (rows[i]) access(rows[i], LANE_HI, 1'b0);
    // Link lanes, packing field and peer access
    @(posedge CLK_SYS) {LINK0_USE, LINK1_USE, IPACK, REQ_FETCH, REQ_PEER} <= 6'b000110;
    access(rows[2], LANE_HI | LANE_MID | LANE_LO, 1'b1);
    @(posedge CLK_SYS) {LINK0_USE, LINK1_USE, IPACK, REQ_FETCH, REQ_PEER} <= 6'b000010;
    access(rows[3], LANE_HI, 1'b0);
    @(posedge CLK_SYS) {LINK0_USE, LINK1_USE, IPACK, REQ_FETCH, REQ_PEER} <= 6'b100000;
    access(rows[1], LANE_HI | LANE_MID, 1'b0);
    @(posedge CLK_SYS) {LINK0_USE, LINK1_USE, IPACK, REQ_FETCH, REQ_PEER} <= 6'b100001;
    access({5'b01000, 4'hF, 28'h1123456}, LANE_HI | LANE_MID, 1'b0);
    @(posedge CLK_SYS) {LINK0_USE, LINK1_USE, IPACK, REQ_FETCH, REQ_PEER} <= 6'b110000;
    @(posedge CLK_SYS);
    BUS_MASTER <= 1'b0;
    EXT_ADDR_I <= {4'h0, PROC_ID, 17'h5};
    ext_rd_n <= 1'b0;
    for (k = 0; k < 9 && !IOP_REQ; k++) @(negedge CLK_SYS);
    chk({IOP_ADDR, RD_N_OE, EXT_ADDR_OE, ACK_OE, ACK_O}, {17'h5, 4'h2});
    @(posedge CLK_SYS) IOP_DONE <= 1'b1;
    IOP_RDATA <= 48'h123456789ABC;
    @(posedge CLK_SYS) IOP_DONE <= 1'b0;
    @(negedge CLK_SYS) chk(EXT_DATA_O & EXT_DATA_OE, 48'h123456780000);
    @(posedge CLK_SYS) ext_rd_n <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    // Host selected write, address outside our identity space
    HOST_SEL_N <= 1'b0;
    ext_wr_n <= 1'b0;
    EXT_ADDR_I <= 24'hF00009;
    BANK_SEL_N_I <= 4'h7;
    for (k = 0; k < 9 && !IOP_REQ; k++) @(negedge CLK_SYS);
    chk({IOP_WRITE, IOP_ADDR, BANK_MON}, {1'b1, 17'h9, 4'h7});
    chk(IOP_WDATA, ~word & LANE_HI);
    @(posedge CLK_SYS) IOP_DONE <= 1'b1;
    @(posedge CLK_SYS) IOP_DONE <= 1'b0;
    ext_wr_n <= 1'b1;
    HOST_SEL_N <= 1'b1;
    BANK_SEL_N_I <= 4'hF;
    repeat (3) @(posedge CLK_SYS);
    BUS_MASTER <= 1'b1;
    BUS_SUSPEND_N <= 1'b0;
    repeat (2) @(negedge CLK_SYS);
    chk({RD_N_OE, BANK_SEL_N_OE, EXT_ADDR_OE}, 3'h0);
    // Reset in mid-run
    @(posedge CLK_SYS) NRST <= 1'b0;
    BUS_SUSPEND_N <= 1'b1;
    repeat (2) @(negedge CLK_SYS);
    chk({RD_N_O, WR_N_O, REQ_READY, ACK_OE, RD_N_OE}, 5'h18);
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (2) @(negedge CLK_SYS);
    chk({KEEP_EN, REQ_READY, RD_N_OE}, 3'h7);
    // Clock enable low freezes the pin enables
    @(posedge CLK_SYS) CE <= 1'b0;
    BUS_SUSPEND_N <= 1'b0;
    repeat (2) @(negedge CLK_SYS);
    chk({RD_N_OE, REQ_READY}, 2'h3);
    report_and_stop;
  end
endmodule
`default_nettype wire
